// [sync_serial_pkg.sv]
// shared constants and types for the synchronous serial port
package sync_serial_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS       = 10;
    localparam int HOST_HALF_PERIOD_NS = 80;
    localparam logic [3:0] HOST_HALF_CYCLES = 4'(HOST_HALF_PERIOD_NS / CLK_PERIOD_NS);

    // ************************************************************
    // character layout
    // ************************************************************
    localparam logic [3:0] LAST_BIT_8   = 4'h7;
    localparam logic [3:0] LAST_BIT_9   = 4'h8;
    localparam int         FIFO_DEPTH   = 2;
    localparam logic [15:0] IRQ_VECTOR  = 16'h0004;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] COUNT_RESET  = 4'h0;
    localparam logic [8:0] WORD_RESET   = 9'h000;

    typedef struct packed {
        logic       ninth;
        logic [7:0] low;
    } rx_char_t;

    typedef struct packed {
        logic leading;
        logic trailing;
    } clk_edges_t;

    localparam rx_char_t CHAR_RESET = '{ninth: 1'b0, low: 8'h00};

endpackage : sync_serial_pkg

// [serial_rx_fifo.sv]
// two-entry receive character buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module serial_rx_fifo (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_sync_b,
    input  wire logic                      clear,
    input  wire logic                      in_valid,
    output logic                           in_ready,
    input  wire sync_serial_pkg::rx_char_t in_data,
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output sync_serial_pkg::rx_char_t      out_data
);
    sync_serial_pkg::rx_char_t mem [sync_serial_pkg::FIFO_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    wire        push = in_valid & in_ready;
    wire        pop  = out_valid & out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
            mem[0] <= sync_serial_pkg::CHAR_RESET;
            mem[1] <= sync_serial_pkg::CHAR_RESET;
        end else if (clear) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : serial_rx_fifo
`default_nettype wire

// [serial_host_clock.sv]
// host serial clock generator with polarity and edge strobes
`timescale 1ns/1ps
`default_nettype none
module serial_host_clock (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_sync_b,
    input  wire logic                   enable,
    input  wire logic                   clock_polarity,
    output logic                        level,
    output sync_serial_pkg::clk_edges_t edges
);
    logic [3:0] count;
    logic       active;
    wire        half_done = (count == sync_serial_pkg::HOST_HALF_CYCLES - 4'h1);

    assign level = active ^ clock_polarity;

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            count  <= sync_serial_pkg::COUNT_RESET;
            active <= 1'b0;
            edges  <= '0;
        end else if (!enable) begin
            // stop at once at the idle level
            count  <= sync_serial_pkg::COUNT_RESET;
            active <= 1'b0;
            edges  <= '0;
        end else begin
            edges <= '0;
            if (half_done) begin
                count          <= sync_serial_pkg::COUNT_RESET;
                active         <= ~active;
                edges.leading  <= ~active;
                edges.trailing <= active;
            end else begin
                count <= count + 4'h1;
            end
        end
    end
endmodule : serial_host_clock
`default_nettype wire

// [sync_serial_port.sv]
// synchronous half-duplex serial port: host/client receive and transmit
// Contract
// [RULE_01] host receiving: data pin driver off, line is input only
// [RULE_02] reception starts when single or continuous receive is set
// [RULE_03] single receive: one clock per bit, then self-clear
// [RULE_04] continuous clocks until cleared; clearing stops and discards
// [RULE_05] both set: single clears after first character
// [RULE_06] sample data on trailing clock edge into receive shift register
// [RULE_07] complete character sets receive flag and enters two-entry buffer
// [RULE_08] receive flag stays set while any unread character is buffered
// [RULE_09] third character with full buffer sets overrun, keeps data, halts
// [RULE_10] single-mode overrun clears on read; continuous on enable clear
// [RULE_11] nine-bit mode shifts nine bits, ninth bit shown separately
// [RULE_12] software reads ninth bit before low byte, which advances buffer
// [RULE_13] client takes clock from pin, clock driver always off
// [RULE_14] driver changes data on leading edge, one bit per clock
// [RULE_15] external host sends no more clocks than character bits
// [RULE_16] transmitter when both receive enables clear, else receiver
// [RULE_17] client transmit: second word waits, flag clear until moved
// [RULE_18] transmit flag wakes only with both enables set
// [RULE_19] client ignores single receive; continuous works asleep
// [RULE_20] only client mode shifts during sleep; others halt
// [RULE_21] wake resumes next instruction, or vector when global enable set
// [RULE_22] software configures before setting a receive enable
// [RULE_23] software empties receive buffer before armed sleep
// [RULE_24] clock polarity sets idle level and leading edge direction
// [RULE_25] port enable clear holds the whole port in reset; buffer entries, shift registers and tx_bit keep their values
// [RULE_26] discarded partial character never sets flag nor enters buffer
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        port_enable,
    input  wire logic        host_select,
    input  wire logic        clock_polarity,
    input  wire logic        single_receive_set,
    input  wire logic        continuous_receive_enable,
    input  wire logic        nine_bit_receive,
    input  wire logic        transmit_enable,
    input  wire logic        nine_bit_transmit,
    input  wire logic        transmit_ninth_bit,
    input  wire logic        transmit_write,
    input  wire logic [7:0]  transmit_data,
    input  wire logic        receive_read,
    input  wire logic        sleep,
    input  wire logic        peripheral_irq_enable,
    input  wire logic        transmit_irq_enable,
    input  wire logic        receive_irq_enable,
    input  wire logic        global_irq_enable,
    input  wire logic        data_line_pin_in,
    output logic             data_line_pin_out,
    output logic             data_line_pin_oe_b,
    input  wire logic        clock_line_pin_in,
    output logic             clock_line_pin_out,
    output logic             clock_line_pin_oe_b,
    output logic             single_receive_enable,
    output logic [7:0]       receive_data_register,
    output logic             received_ninth_bit,
    output logic             receive_flag,
    output logic             overrun_flag,
    output logic             transmit_flag,
    output logic             wake,
    output logic             vector_take,
    output logic [15:0]      vector_addr
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [3:0] char_last(input logic nine);
        char_last = nine ? sync_serial_pkg::LAST_BIT_9 : sync_serial_pkg::LAST_BIT_8;
    endfunction : char_last

    // ************************************************************
    // reset release and pin synchronisers
    // ************************************************************
    logic rst_meta;
    logic rst_sync_b;
    logic data_meta;
    logic data_s;
    logic ck_meta;
    logic ck_s;
    logic ck_prev;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            data_meta <= 1'b0;
            data_s    <= 1'b0;
            ck_meta   <= 1'b0;
            ck_s      <= 1'b0;
            ck_prev   <= 1'b0;
        end else begin
            data_meta <= data_line_pin_in;
            data_s    <= data_meta;
            ck_meta   <= clock_line_pin_in;
            ck_s      <= ck_meta;
            ck_prev   <= ck_s;
        end
    end

    // ************************************************************
    // mode decode
    // ************************************************************
    logic                        rx_dir;
    logic                        rx_active;
    logic                        tx_busy;
    logic                        host_clk_en;
    logic                        host_level;
    sync_serial_pkg::clk_edges_t host_edges;
    sync_serial_pkg::clk_edges_t pin_edges;
    sync_serial_pkg::clk_edges_t link;
    wire                         awake_ok = ~host_select | ~sleep;                 // [RULE_20]

    assign rx_dir = host_select ? (single_receive_enable | continuous_receive_enable) // [RULE_02]
                                : continuous_receive_enable;                       // [RULE_19]
    assign rx_active = port_enable & rx_dir & ~overrun_flag & awake_ok;           // [RULE_16]
    assign host_clk_en = port_enable & host_select & ~sleep
                       & (rx_dir ? ~overrun_flag : tx_busy);                       // [RULE_03]
    assign pin_edges.leading  = (ck_s != clock_polarity) & (ck_prev == clock_polarity); // [RULE_24]
    assign pin_edges.trailing = (ck_s == clock_polarity) & (ck_prev != clock_polarity); // [RULE_24]
    assign link = host_select ? host_edges : pin_edges;                            // [RULE_13]

    serial_host_clock u_host_clock (
        .ref_clk        (ref_clk),
        .rst_sync_b     (rst_sync_b),
        .enable         (host_clk_en),
        .clock_polarity (clock_polarity),
        .level          (host_level),
        .edges          (host_edges)
    );

    // ************************************************************
    // receiver
    // ************************************************************
    logic [3:0]                rx_cnt;
    logic [8:0]                rx_word;
    logic [8:0]                next_rx_word;
    logic                      overrun_single;
    sync_serial_pkg::rx_char_t rx_char;
    sync_serial_pkg::rx_char_t fifo_head;
    logic                      fifo_in_ready;
    wire                       rx_last   = (rx_cnt == char_last(nine_bit_receive));
    wire                       char_done = link.trailing & rx_active & rx_last;
    wire                       overrun_set = char_done & ~fifo_in_ready;       // [RULE_09]
    wire                       overrun_clr = overrun_single ? receive_read
                                             : ~continuous_receive_enable;     // [RULE_10]

    always_comb begin
        next_rx_word         = rx_word;
        next_rx_word[rx_cnt] = data_s;                                         // [RULE_06]
    end

    assign rx_char.ninth = nine_bit_receive & next_rx_word[8];                 // [RULE_11]
    assign rx_char.low   = next_rx_word[7:0];

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rx_cnt  <= sync_serial_pkg::COUNT_RESET;
            rx_word <= sync_serial_pkg::WORD_RESET;
        end else if (!port_enable || !rx_active) begin
            rx_cnt  <= sync_serial_pkg::COUNT_RESET;                           // [RULE_04] [RULE_26]
        end else if (link.trailing) begin
            rx_word <= next_rx_word;                                           // [RULE_06]
            rx_cnt  <= rx_last ? sync_serial_pkg::COUNT_RESET : rx_cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            single_receive_enable <= 1'b0;
            overrun_flag          <= 1'b0;
            overrun_single        <= 1'b0;
        end else if (!port_enable) begin
            single_receive_enable <= 1'b0;                                     // [RULE_25]
            overrun_flag          <= 1'b0;
            overrun_single        <= 1'b0;
        end else begin
            if (char_done && host_select) begin
                single_receive_enable <= 1'b0;                                 // [RULE_05]
            end else if (single_receive_set && host_select) begin
                single_receive_enable <= 1'b1;                                 // [RULE_03]
            end
            if (overrun_set) begin
                overrun_flag   <= 1'b1;                                        // [RULE_09]
                overrun_single <= ~continuous_receive_enable;
            end else if (overrun_flag && overrun_clr) begin
                overrun_flag   <= 1'b0;                                        // [RULE_10]
            end
        end
    end

    serial_rx_fifo u_rx_fifo (
        .ref_clk    (ref_clk),
        .rst_sync_b (rst_sync_b),
        .clear      (~port_enable),
        .in_valid   (char_done),
        .in_ready   (fifo_in_ready),
        .in_data    (rx_char),
        .out_valid  (receive_flag),                                            // [RULE_08]
        .out_ready  (receive_read),
        .out_data   (fifo_head)
    );

    // head of buffer shown directly; read pops it
    assign receive_data_register = fifo_head.low;                              // [RULE_07]
    assign received_ninth_bit    = fifo_head.ninth;                            // [RULE_11]

    // ************************************************************
    // transmitter
    // ************************************************************
    logic       hold_valid;
    logic [8:0] hold_word;
    logic [8:0] tsr_word;
    logic [3:0] tx_cnt;
    logic       tx_bit;
    wire        tx_dir  = port_enable & transmit_enable & ~rx_dir;            // [RULE_16]
    wire        tx_move = tx_dir & awake_ok & hold_valid & ~tx_busy;          // [RULE_17]
    wire        tx_last = (tx_cnt == char_last(nine_bit_transmit));

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hold_valid <= 1'b0;
            hold_word  <= sync_serial_pkg::WORD_RESET;
        end else if (!port_enable) begin
            hold_valid <= 1'b0;                                                // [RULE_25]
        end else begin
            hold_valid <= transmit_write | (hold_valid & ~tx_move);            // [RULE_17]
            if (transmit_write) begin
                hold_word <= {transmit_ninth_bit, transmit_data};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_busy  <= 1'b0;
            tsr_word <= sync_serial_pkg::WORD_RESET;
            tx_cnt   <= sync_serial_pkg::COUNT_RESET;
            tx_bit   <= 1'b0;
        end else if (!port_enable || !tx_dir) begin
            tx_busy  <= 1'b0;                                                  // [RULE_25]
            tx_cnt   <= sync_serial_pkg::COUNT_RESET;
        end else if (tx_move) begin
            tx_busy  <= 1'b1;                                                  // [RULE_17]
            tsr_word <= hold_word;
            tx_cnt   <= sync_serial_pkg::COUNT_RESET;
        end else if (tx_busy && awake_ok) begin
            if (link.leading) begin
                tx_bit <= tsr_word[tx_cnt];                                    // [RULE_14]
            end
            if (link.trailing) begin
                tx_cnt  <= tx_last ? sync_serial_pkg::COUNT_RESET : tx_cnt + 4'h1;
                tx_busy <= ~tx_last;
            end
        end
    end

    assign transmit_flag = port_enable & ~hold_valid;                          // [RULE_17]

    // ************************************************************
    // pins
    // ************************************************************
    assign data_line_pin_out   = tx_bit;
    assign data_line_pin_oe_b  = ~tx_dir;                                      // [RULE_01]
    assign clock_line_pin_out  = host_level;                                   // [RULE_24]
    assign clock_line_pin_oe_b = ~(port_enable & host_select);                 // [RULE_13]

    // ************************************************************
    // wake from sleep
    // ************************************************************
    logic tx_flag_prev;
    logic rx_flag_prev;
    wire  tx_wake = transmit_flag & ~tx_flag_prev
                  & peripheral_irq_enable & transmit_irq_enable;               // [RULE_18]
    wire  rx_wake = receive_flag & ~rx_flag_prev
                  & peripheral_irq_enable & receive_irq_enable;                // [RULE_19]

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_flag_prev <= 1'b0;
            rx_flag_prev <= 1'b0;
            wake         <= 1'b0;
            vector_take  <= 1'b0;
        end else begin
            tx_flag_prev <= transmit_flag;
            rx_flag_prev <= receive_flag;
            wake         <= sleep & (tx_wake | rx_wake);                       // [RULE_21]
            vector_take  <= sleep & (tx_wake | rx_wake) & global_irq_enable;   // [RULE_21]
        end
    end

    assign vector_addr = sync_serial_pkg::IRQ_VECTOR;

endmodule : sync_serial_port
`default_nettype wire

// [sync_serial_port_properties.sv]
// concurrent checks on the serial port pins and flags
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_properties (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        port_enable,
    input wire logic        host_select,
    input wire logic        clock_polarity,
    input wire logic        continuous_receive_enable,
    input wire logic        receive_read,
    input wire logic        sleep,
    input wire logic        peripheral_irq_enable,
    input wire logic        global_irq_enable,
    input wire logic        data_line_pin_oe_b,
    input wire logic        clock_line_pin_out,
    input wire logic        clock_line_pin_oe_b,
    input wire logic        single_receive_enable,
    input wire logic        receive_flag,
    input wire logic        overrun_flag,
    input wire logic        transmit_flag,
    input wire logic        wake,
    input wire logic        vector_take,
    input wire logic [15:0] vector_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_rx_data_released: assert property (port_enable && host_select &&
        (single_receive_enable || continuous_receive_enable) |-> data_line_pin_oe_b)
        else $error("data pin driven");
    a_client_clock_input: assert property (port_enable && !host_select
        |-> clock_line_pin_oe_b) else $error("clock pin driven");
    a_single_then_flag: assert property ($fell(single_receive_enable) && port_enable
        |-> ##1 receive_flag) else $error("no character");
    a_flag_holds: assert property (receive_flag && !receive_read && port_enable
        |=> receive_flag) else $error("flag dropped");
    a_overrun_sticky: assert property (overrun_flag && continuous_receive_enable
        && port_enable |=> overrun_flag) else $error("overrun lost");
    a_overrun_cont_clear: assert property ($fell(continuous_receive_enable)
        |=> !overrun_flag) else $error("overrun kept");
    a_disable_resets: assert property (!port_enable |=> !receive_flag &&
        !overrun_flag && !single_receive_enable) else $error("state kept");
    a_disabled_idle: assert property (!port_enable |-> !transmit_flag &&
        clock_line_pin_oe_b && data_line_pin_oe_b && clock_line_pin_out == clock_polarity)
        else $error("not idle");
    a_wake_gated: assert property (wake |-> sleep && peripheral_irq_enable)
        else $error("bad wake");
    a_vector_with_wake: assert property (vector_take |-> wake && global_irq_enable
        && vector_addr == 16'h0004) else $error("bad vector");
endmodule : sync_serial_port_properties
bind sync_serial_port sync_serial_port_properties chk (.*);
`default_nettype wire

// [serial_far_end.sv]
// far-end party: clocks frames as host, shifts data on the line edges
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
    input  wire logic clk_wire,
    input  wire logic dat_wire,
    input  wire logic pol,
    output logic      clk_drv,
    output logic      dat_drv
);
    logic [8:0] tx_word = 9'h000;
    logic [8:0] rx_word = 9'h000;
    int nb = 8, n = 0, cnt = 0;
    initial clk_drv = 1'b0;
    initial dat_drv = 1'b1;
    task automatic load(input logic [8:0] w, input int bits);
        tx_word = w;
        nb = bits;
        n = 0;
        cnt = 0;
        clk_drv = pol;
    endtask : load
    task automatic frame;
        repeat (nb) begin
            clk_drv = ~pol;
            #80 clk_drv = pol;
            #80;
        end
    endtask : frame
    always @(clk_wire) begin
        if (clk_wire !== pol) begin
            dat_drv = tx_word[n];
        end else begin
            rx_word[n] = dat_wire;
            cnt++;
            n = (n + 1) % nb;
            dat_drv <= #40 ~dat_drv;
        end
    end
endmodule : serial_far_end
`default_nettype wire

// [test_sync_serial_receive_and_client.sv]
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_receive_and_client;
    logic ref_clk = 1'b0, rst_b = 1'b0, port_enable = 1'b0, host_select = 1'b1;
    logic clock_polarity = 1'b0, single_receive_set = 1'b0, continuous_receive_enable = 1'b0;
    logic nine_bit_receive = 1'b0, transmit_enable = 1'b0, transmit_write = 1'b0;
    logic receive_read = 1'b0, sleep = 1'b0, peripheral_irq_enable = 1'b0;
    logic transmit_irq_enable = 1'b0, receive_irq_enable = 1'b0, global_irq_enable = 1'b0;
    logic [7:0] transmit_data = 8'h00, receive_data_register;
    logic [15:0] vector_addr;
    logic data_line_pin_out, data_line_pin_oe_b, clock_line_pin_out, clock_line_pin_oe_b;
    logic single_receive_enable, received_ninth_bit, receive_flag, overrun_flag;
    logic transmit_flag, wake, vector_take, dat_wire, clk_wire, dat_drv, clk_drv;
    logic [8:0] c;
    int n_fail = 0, tests_run = 0, cyc = 0, n_wake = 0, n_vec = 0;
    always #5 ref_clk = ~ref_clk;
    assign dat_wire = data_line_pin_oe_b ? dat_drv : data_line_pin_out;
    assign clk_wire = clock_line_pin_oe_b ? clk_drv : clock_line_pin_out;
    sync_serial_port uut (.*, .nine_bit_transmit(1'b0), .transmit_ninth_bit(1'b0),
        .data_line_pin_in(dat_wire), .clock_line_pin_in(clk_wire));
    serial_far_end far (.clk_wire, .dat_wire, .pol(clock_polarity), .clk_drv, .dat_drv);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic tick(input int k = 1);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic pulse_single;
        single_receive_set = 1'b1;
        tick();
        single_receive_set = 1'b0;
    endtask : pulse_single
    task automatic wait_rx;
        for (int i = 0; i < 400 && receive_flag !== 1'b1; i++) tick();
    endtask : wait_rx
    task automatic read_char;
        c = {received_ninth_bit, receive_data_register};
        receive_read = 1'b1;
        tick();
        receive_read = 1'b0;
        tick();
    endtask : read_char
    task automatic host_single;
        far.load(9'h0A5, 8);
        port_enable = 1'b1;
        tick(3);
        pulse_single();
        check(single_receive_enable, 1, "armed");
        wait_rx();
        check(receive_flag, 1, "flag");
        check(single_receive_enable, 0, "self clear");
        tick(100);
        check(9'(far.cnt), 8, "clocks");
        read_char();
        check(c[7:0], 8'hA5, "byte");
        check(receive_flag, 0, "empty");
    endtask : host_single
    task automatic host_overrun;
        far.load(9'h1C3, 9);
        nine_bit_receive = 1'b1;
        continuous_receive_enable = 1'b1;
        pulse_single();
        wait_rx();
        check(single_receive_enable, 0, "single off");
        for (int i = 0; i < 900 && overrun_flag !== 1'b1; i++) tick();
        tick(100);
        check(overrun_flag, 1, "overrun");
        check(9'(far.cnt), 27, "overrun stop");
        read_char();
        check(c, 9'h1C3, "first");
        read_char();
        check(c, 9'h1C3, "second");
        check(overrun_flag, 1, "kept");
        continuous_receive_enable = 1'b0;
        tick(2);
        check(overrun_flag, 0, "cleared");
        nine_bit_receive = 1'b0;
    endtask : host_overrun
    task automatic host_abort;
        far.load(9'h0FF, 8);
        continuous_receive_enable = 1'b1;
        for (int i = 0; i < 400 && far.cnt < 4; i++) tick();
        continuous_receive_enable = 1'b0;
        tick(60);
        check(9'(far.cnt), 4, "stop");
        check(receive_flag, 0, "dropped");
    endtask : host_abort
    task automatic client_rx;
        host_select = 1'b0;
        tick(2);
        pulse_single();
        check(single_receive_enable, 0, "ignored");
        far.load(9'h03C, 8);
        peripheral_irq_enable = 1'b1;
        receive_irq_enable = 1'b1;
        continuous_receive_enable = 1'b1;
        sleep = 1'b1;
        n_wake = 0;
        tick(2);
        far.frame();
        tick(10);
        check(receive_flag, 1, "asleep");
        check(9'(n_wake), 1, "rx wake");
        sleep = 1'b0;
        continuous_receive_enable = 1'b0;
        read_char();
        check(c[7:0], 8'h3C, "client");
    endtask : client_rx
    task automatic client_tx;
        receive_irq_enable = 1'b0;
        transmit_enable = 1'b1;
        transmit_irq_enable = 1'b1;
        global_irq_enable = 1'b1;
        transmit_data = 8'h96;
        transmit_write = 1'b1;
        tick();
        transmit_data = 8'h5A;
        tick();
        transmit_write = 1'b0;
        tick(2);
        check(transmit_flag, 0, "waits");
        sleep = 1'b1;
        n_wake = 0;
        far.load(9'h000, 8);
        far.frame();
        tick(10);
        check(far.rx_word[7:0], 8'h96, "tx first");
        check(transmit_flag, 1, "moved");
        check(9'(n_wake), 1, "tx wake");
        check(9'(n_vec), 1, "vector");
        far.load(9'h000, 8);
        far.frame();
        tick(10);
        check(far.rx_word[7:0], 8'h5A, "tx second");
        port_enable = 1'b0;
        tick(3);
        check(transmit_flag, 0, "disabled");
    endtask : client_tx
    always @(posedge ref_clk) begin
        cyc++;
        if (wake === 1'b1) n_wake++;
        if (vector_take === 1'b1) n_vec++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        tick(10);
        rst_b = 1'b1;
        tick(3);
        host_single();
        host_overrun();
        host_abort();
        client_rx();
        client_tx();
        report_and_stop();
    end
endmodule : test_sync_serial_receive_and_client
`default_nettype wire
